// ==== design/lpw_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] answer address 11011 plus two select bits
// [RULE2] write transfers only; direction bit zero
// [RULE3] select pin tie gives the low bits
// [RULE4] sample data while clock high; idle high
// [RULE5] start and stop from data edge, clock high
// [RULE6] acknowledge matching address on ninth clock
// [RULE7] host stops transfer when no acknowledge
// [RULE8] register index byte follows, acknowledged
// [RULE9] data bytes follow, each acknowledged
// [RULE10] store at pointer, increment during acknowledge
// [RULE11] index 00 bit 0: zero shuts down
// [RULE12] duty value over 256 per channel
// [RULE13] duty and scale staged until commit write
// [RULE14] per-channel six-bit current scale code
// [RULE15] upper scale codes decode to fractions
// [RULE16] lower codes decode; top bits 00 off
// [RULE17] global bit zero means normal output
// [RULE18] frequency bit picks fast or slow pwm
// [RULE19] defaults command and power-up restore defaults
// [RULE20] shutdown forces outputs off, keeps registers
// [RULE21] global bit one forces outputs off
// [RULE22] unmapped indices acknowledged and discarded
// [RULE23] one shared free-running eight-bit period counter
module lpw_dev
  import lpw_pkg::*;
#(
  parameter int N_CH = NUM_CH
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // serial link
  lpw_link_if.dev                   link,
  // channel drive
  output logic [N_CH-1:0]           channel_outputs,
  output logic [N_CH-1:0][4:0]      channel_level
);
  typedef struct packed {
    logic [1:0]                scl_sy;
    logic [1:0]                sda_sy;
    logic [1:0]                ad_sy;
    logic                      scl_d;
    logic                      sda_d;
    logic                      ad_d;
    logic                      ad_at_start;
    logic [1:0]                ad_bits;
    lpw_dev_st_type            st;
    lpw_byte_type              bk;
    logic [3:0]                bitn;
    logic [7:0]                shreg;
    logic [7:0]                ptr;
    logic                      sda_oe;
    logic                      soft_on;
    logic                      glob_off;
    logic                      freq_slow;
    logic [N_CH-1:0][7:0]      duty_sh;
    logic [N_CH-1:0][7:0]      duty_act;
    logic [N_CH-1:0][5:0]      current_scale_code;
    logic [N_CH-1:0][5:0]      scale_act;
    logic [7:0]                presc;
    logic [7:0]                pwm_cnt;
    logic [N_CH-1:0]           outs;
    logic [N_CH-1:0][4:0]      lvl;
  } lpw_dev_state_type;

  lpw_dev_state_type    q;
  lpw_dev_state_type    s;
  logic                 scl;
  logic                 sda;
  logic                 ad;
  logic                 rise;
  logic                 fall;
  logic                 start;
  logic                 stop;
  logic                 out_ok;
  logic [7:0]           duty_idx;
  logic [7:0]           scale_idx;
  logic [7:0]           div_end;
  logic [N_CH-1:0]      on_nxt;
  logic [N_CH-1:0][4:0] lvl_nxt;

  // only the second stage of each synchroniser is looked at
  assign scl   = q.scl_sy[1];
  assign sda   = q.sda_sy[1];
  assign ad    = q.ad_sy[1];
  assign rise  = scl & ~q.scl_d;
  assign fall  = ~scl & q.scl_d;
  assign start = scl & q.scl_d & q.sda_d & ~sda; // see [RULE5]
  assign stop  = scl & q.scl_d & ~q.sda_d & sda; // see [RULE5]

  // index offsets into the duty and scale banks
  assign duty_idx  = q.ptr - REG_DUTY_FIRST;
  assign scale_idx = q.ptr - REG_SCALE_FIRST;

  // outputs may light only when neither shutdown path is active
  assign out_ok  = q.soft_on & ~q.glob_off; // see [RULE11] [RULE17] [RULE20] [RULE21]
  assign div_end = q.freq_slow ? 8'(DIV_SLOW - 1) : 8'(DIV_FAST - 1); // see [RULE18]

  // per-channel compare against the shared period counter
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    assign on_nxt[c] = out_ok & ((q.scale_act[c] & SCALE_ON_MASK) != 6'h00) // see [RULE16]
                       & (q.pwm_cnt < q.duty_act[c]); // see [RULE12] [RULE23]
    assign lvl_nxt[c] = out_ok ? lpw_scale_level(q.scale_act[c]) : 5'h00; // see [RULE15] [RULE16]
  end

  always_comb begin
    s = q;
    s.scl_sy = {q.scl_sy[0], link.scl};
    s.sda_sy = {q.sda_sy[0], link.sda};
    s.ad_sy  = {q.ad_sy[0], link.ad};
    s.scl_d  = scl;
    s.sda_d  = sda;
    s.ad_d   = ad;

    // select pin: level at start, then level while clock low before bit 7;
    // bit 7 of the address is one, so a pin tied to data reads high there
    if (start) s.ad_at_start = ad; // see [RULE3]
    if (rise && q.st == ds_rx && q.bk == bk_addr && q.bitn == 4'h0) begin
      s.ad_bits = {q.ad_d, q.ad_at_start}; // see [RULE3]
    end

    // a start aborts anything in progress, a stop returns to idle
    if (start) begin
      s.st     = ds_rx;
      s.bk     = bk_addr;
      s.bitn   = 4'h0;
      s.sda_oe = 1'b0;
    end else if (stop) begin
      s.st     = ds_idle;
      s.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ds_idle, ds_skip: ;
        ds_rx: begin
          if (rise && q.bitn < 4'h8) begin
            s.shreg = {q.shreg[6:0], sda}; // see [RULE4]
            s.bitn  = q.bitn + 4'h1;
          end
          // the byte is judged at the eighth falling clock edge
          if (fall && q.bitn == 4'h8) begin
            s.st     = ds_ack;
            s.sda_oe = 1'b1;
            unique case (q.bk)
              bk_addr: begin
                if (q.shreg != {DEV_ADDR_HI, q.ad_bits, DIR_WRITE}) begin // see [RULE1] [RULE2]
                  s.st     = ds_skip;
                  s.sda_oe = 1'b0;
                end else begin
                  s.bk = bk_index; // see [RULE6]
                end
              end
              bk_index: begin
                s.ptr = q.shreg; // see [RULE8]
                s.bk  = bk_data;
              end
              bk_data: begin
                s.ptr = q.ptr + 8'h01; // see [RULE9] [RULE10]
                if (q.ptr == REG_SOFT_OFF) begin
                  s.soft_on = q.shreg[BIT_D0]; // see [RULE11]
                end else if (q.ptr >= REG_DUTY_FIRST && duty_idx < 8'(N_CH)) begin
                  s.duty_sh[duty_idx] = q.shreg; // see [RULE13]
                end else if (q.ptr == REG_COMMIT) begin
                  if (q.shreg == CMD_MAGIC) begin
                    s.duty_act  = q.duty_sh; // see [RULE13]
                    s.scale_act = q.current_scale_code;
                  end
                end else if (q.ptr >= REG_SCALE_FIRST && scale_idx < 8'(N_CH)) begin
                  s.current_scale_code[scale_idx] = q.shreg[5:0]; // see [RULE14]
                end else if (q.ptr == REG_GLOBAL) begin
                  s.glob_off = q.shreg[BIT_D0]; // see [RULE17] [RULE21]
                end else if (q.ptr == REG_FREQ) begin
                  s.freq_slow = q.shreg[BIT_D0]; // see [RULE18]
                end else if (q.ptr == REG_DEFAULTS) begin
                  if (q.shreg == CMD_MAGIC) begin
                    s.soft_on            = 1'b0; // see [RULE19]
                    s.glob_off           = 1'b0;
                    s.freq_slow          = 1'b0;
                    s.duty_sh            = {N_CH{DUTY_RST}};
                    s.duty_act           = {N_CH{DUTY_RST}};
                    s.current_scale_code = {N_CH{SCALE_RST}};
                    s.scale_act          = {N_CH{SCALE_RST}};
                  end
                end
                // any other index is acknowledged and dropped, see [RULE22]
              end
              default: begin
                s.st     = ds_skip;
                s.sda_oe = 1'b0;
              end
            endcase
          end
        end
        ds_ack: begin
          // release the line after the ninth clock goes low again
          if (fall) begin
            s.sda_oe = 1'b0; // see [RULE6] [RULE9]
            s.st     = ds_rx;
            s.bitn   = 4'h0;
          end
        end
      endcase
    end

    // prescaler picks the step rate; the period counter never stops,
    // so all channels switch on together at the counter wrap
    if (q.presc >= div_end) begin
      s.presc   = 8'h00;
      s.pwm_cnt = q.pwm_cnt + 8'h01; // see [RULE23]
    end else begin
      s.presc = q.presc + 8'h01;
    end
    s.outs = on_nxt;
    s.lvl  = lvl_nxt;
  end

  // power-up loads every register with its default value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0; // see [RULE19]
    end else begin
      q <= s;
    end
  end

  assign channel_outputs = q.outs;
  assign channel_level   = q.lvl;
  assign link.sda_s_o    = 1'b0;
  assign link.sda_s_oe   = q.sda_oe;
endmodule
`default_nettype wire

// ==== design/lpw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpw_host
  import lpw_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial link
  lpw_link_if.host         link
);
  typedef struct packed {
    logic [1:0]      sda_sy;
    lpw_host_st_type st;
    logic [3:0]      qcnt;
    logic [1:0]      ph;
    logic [3:0]      bitn;
    logic [1:0]      byten;
    logic [1:0]      last;
    logic [7:0]      shreg;
    logic [3:0][7:0] frame;
    logic            nack;
    logic            busy;
    logic            scl_o;
    logic            sda_oe;
    logic            sda_o;
    logic            wreq;
    logic [31:0]     rdata;
  } lpw_host_state_type;

  lpw_host_state_type q;
  lpw_host_state_type s;
  logic               sda_in;
  logic               tick;
  logic               go;

  assign sda_in = q.sda_sy[1];
  assign tick   = (q.qcnt == 4'h0);
  // a go write completes at the edge where waitrequest is seen low
  assign go = avs_write & ~q.wreq & (avs_address == H_REG_CTRL) & avs_writedata[CTRL_GO_BIT];

  always_comb begin
    s = q;
    s.sda_sy = {q.sda_sy[0], link.sda};
    // one wait cycle on every access: answer lands on the second cycle
    s.wreq = ~((avs_read | avs_write) & q.wreq);
    if (avs_read & q.wreq) begin
      s.rdata = 32'h0;
      if (avs_address == H_REG_STATUS) begin
        s.rdata[STAT_BUSY_BIT] = q.busy;
        s.rdata[STAT_NACK_BIT] = q.nack;
      end
    end
    if (q.st != hs_idle) begin
      s.qcnt = tick ? 4'(SCL_QTR - 1) : q.qcnt - 4'h1;
      if (tick) s.ph = q.ph + 2'h1;
    end
    unique case (q.st)
      hs_idle: begin
        // a go while busy cannot happen here, so no queueing is needed
        if (go) begin
          s.frame[0] = {DEV_ADDR_HI, avs_writedata[CTRL_AD_LSB +: 2], DIR_WRITE}; // see [RULE2]
          s.frame[1] = avs_writedata[CTRL_IDX_LSB +: 8];
          s.frame[2] = avs_writedata[CTRL_D0_LSB +: 8];
          s.frame[3] = avs_writedata[CTRL_D1_LSB +: 8];
          s.last  = avs_writedata[CTRL_TWO_BIT] ? 2'h3 : 2'h2;
          s.st    = hs_start;
          s.ph    = 2'h0;
          s.qcnt  = 4'(SCL_QTR - 1);
          s.busy  = 1'b1;
          s.nack  = 1'b0;
        end
      end
      hs_start: begin
        // data falls while the clock is high, then the clock drops
        if (tick && q.ph == 2'h1) s.sda_oe = 1'b1; // see [RULE5]
        if (tick && q.ph == 2'h2) s.scl_o = 1'b0;
        if (tick && q.ph == 2'h3) begin
          s.st    = hs_bits;
          s.bitn  = 4'h0;
          s.byten = 2'h0;
          s.shreg = q.frame[0];
        end
      end
      hs_bits: begin
        if (tick) begin
          unique case (q.ph)
            // data changes only while the clock is low, msb first
            2'h0: s.sda_oe = (q.bitn < 4'h8) ? ~q.shreg[7] : 1'b0; // see [RULE4] [RULE6]
            2'h1: s.scl_o = 1'b1;
            2'h2: ;
            2'h3: begin
              s.scl_o = 1'b0;
              if (q.bitn < 4'h8) begin
                s.shreg = {q.shreg[6:0], 1'b0};
                s.bitn  = q.bitn + 4'h1;
              end else if (sda_in) begin
                s.nack = 1'b1; // see [RULE7]
                s.st   = hs_stop;
              end else if (q.byten == q.last) begin
                s.st = hs_stop;
              end else begin
                s.byten = q.byten + 2'h1; // see [RULE8] [RULE9]
                s.shreg = q.frame[q.byten + 2'h1];
                s.bitn  = 4'h0;
              end
            end
          endcase
        end
      end
      hs_stop: begin
        // pull data low, raise clock, then release data while clock high
        if (tick && q.ph == 2'h0) s.sda_oe = 1'b1;
        if (tick && q.ph == 2'h1) s.scl_o = 1'b1;
        if (tick && q.ph == 2'h2) s.sda_oe = 1'b0; // see [RULE5]
        if (tick && q.ph == 2'h3) begin
          s.busy = 1'b0;
          s.st   = hs_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.wreq  <= 1'b1;
      q.scl_o <= 1'b1;
    end else begin
      q <= s;
    end
  end

  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign link.scl        = q.scl_o;
  assign link.sda_m_o    = q.sda_o;
  assign link.sda_m_oe   = q.sda_oe;
endmodule
`default_nettype wire

// ==== design/lpw_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lpw_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  logic ad;

  // open-drain data line with pull-up: any enabled low driver wins
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport host (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport dev  (input scl, input sda, input ad, output sda_s_o, output sda_s_oe);
endinterface
`default_nettype wire

// ==== design/lpw_pkg.sv ====
package lpw_pkg;
  // system clock and channel count
  localparam int CLK_HZ = 10_000_000;
  localparam int NUM_CH = 18;

  // bus address: fixed high part, write-only direction bit
  localparam logic [4:0] DEV_ADDR_HI = 5'h1B;
  localparam logic       DIR_WRITE   = 1'h0;

  // device register indices
  localparam logic [7:0] REG_SOFT_OFF    = 8'h00;
  localparam logic [7:0] REG_DUTY_FIRST  = 8'h01;
  localparam logic [7:0] REG_COMMIT      = 8'h13;
  localparam logic [7:0] REG_SCALE_FIRST = 8'h14;
  localparam logic [7:0] REG_GLOBAL      = 8'h26;
  localparam logic [7:0] REG_FREQ        = 8'h27;
  localparam logic [7:0] REG_DEFAULTS    = 8'h2F;
  localparam logic [7:0] CMD_MAGIC       = 8'h00;
  localparam int         BIT_D0          = 0;
  localparam logic [5:0] SCALE_ON_MASK   = 6'h30;

  // power-up values
  localparam logic [7:0] DUTY_RST  = 8'h00;
  localparam logic [5:0] SCALE_RST = 6'h00;

  // pwm rates in centi-hertz, one period is 256 steps
  localparam longint PWM_FAST_CHZ = 2_300_000;
  localparam longint PWM_SLOW_CHZ = 345_000;
  localparam longint PWM_STEPS    = 256;
  localparam int DIV_FAST = int'((longint'(CLK_HZ) * 100) / (PWM_FAST_CHZ * PWM_STEPS));
  localparam int DIV_SLOW = int'((longint'(CLK_HZ) * 100) / (PWM_SLOW_CHZ * PWM_STEPS));

  // serial clock: a quarter period, rounded up so the rate stays legal
  localparam int SCL_MAX_HZ = 400_000;
  localparam int SCL_QTR    = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);

  // controller registers, byte addresses, and their fields
  localparam logic [3:0] H_REG_CTRL   = 4'h0;
  localparam logic [3:0] H_REG_STATUS = 4'h4;
  localparam int CTRL_IDX_LSB  = 0;
  localparam int CTRL_D0_LSB   = 8;
  localparam int CTRL_D1_LSB   = 16;
  localparam int CTRL_TWO_BIT  = 24;
  localparam int CTRL_AD_LSB   = 25;
  localparam int CTRL_GO_BIT   = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  typedef enum logic [1:0] {ds_idle, ds_rx, ds_ack, ds_skip} lpw_dev_st_type;
  typedef enum logic [1:0] {bk_addr, bk_index, bk_data} lpw_byte_type;
  typedef enum logic [1:0] {hs_idle, hs_start, hs_bits, hs_stop} lpw_host_st_type;

  // current-scale code to numerator over 24; unlisted codes give off
  function automatic logic [4:0] lpw_scale_level(input logic [5:0] code);
    case (code)
      6'h30:   return 5'h18;
      6'h31:   return 5'h17;
      6'h35:   return 5'h16;
      6'h32:   return 5'h15;
      6'h36:   return 5'h14;
      6'h33:   return 5'h13;
      6'h3A:   return 5'h12;
      6'h3E:   return 5'h10;
      6'h3F:   return 5'h0E;
      6'h10:   return 5'h0C;
      6'h11:   return 5'h0B;
      6'h12:   return 5'h09;
      6'h13:   return 5'h07;
      default: return 5'h00;
    endcase
  endfunction
endpackage

// ==== verification/lpw_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpw_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bit_cnt_r;

  // scl pulses since the last start, wrapping after the ninth
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      bit_cnt_r <= 4'h0;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (scl && scl_q_r && sda_q_r && !sda) begin
        bit_cnt_r <= 4'h0;
      end else if (scl && !scl_q_r) begin
        bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
      end
    end
  end

  a_ack_on_ninth: assert property ($rose(scl) && sda_s_oe |-> bit_cnt_r == 4'h8)
    else $error("ack outside the ninth pulse");
  a_host_ack_release: assert property ($rose(scl) && bit_cnt_r == 4'h8 |-> !sda_m_oe)
    else $error("host holds data in the ack slot");
  a_ack_rise_low: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("ack driven while clock high");
  a_ack_hold_high: assert property ($fell(sda_s_oe) |-> !scl && !$past(scl))
    else $error("ack dropped inside the pulse");
  a_ack_span_bound: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8] ##[8:30] !sda_s_oe)
    else $error("ack length out of range");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*7])
    else $error("clock high too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8] ##1 !scl [*5])
    else $error("clock low too short");
  a_data_stable_high: assert property ($rose(scl) |-> $stable(sda_m_oe) [*3])
    else $error("data moved in clock high");
  a_start_scl_fall: assert property (scl && $fell(sda) |-> scl [*3] ##[1:10] !scl)
    else $error("start not followed by clock");
  a_stop_bus_free: assert property (scl && $rose(sda) |-> (scl && sda) [*8])
    else $error("bus not idle after stop");

  // main traffic seen
  cover property ($rose(sda_s_oe));
  cover property ($rose(scl) && bit_cnt_r == 4'h8 && !sda_s_oe);
  cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import lpw_pkg::*;;
  logic             clk_sys;
  logic             rst;
  logic [3:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [17:0]      channel_outputs;
  logic [17:0][4:0] channel_level;
  logic [1:0]       ad_mode;
  logic             nk;
  int               mismatches;
  int               cmp_count;
  int               c0;
  int               c1;
  int               cx;
  // scale codes and their numerators over 24
  localparam logic [5:0] SC [14] = '{6'h30, 6'h31, 6'h35, 6'h32, 6'h36, 6'h33, 6'h3A,
                                     6'h3E, 6'h3F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h0F};
  localparam logic [4:0] LV [14] = '{5'h18, 5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12,
                                     5'h10, 5'h0E, 5'h0C, 5'h0B, 5'h09, 5'h07, 5'h00};

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  lpw_link_if link ();
  // select pin tie: ground, supply, clock line or data line
  assign link.ad = (ad_mode == 2'h0) ? 1'b0 : (ad_mode == 2'h1) ? 1'b1 :
                   (ad_mode == 2'h2) ? link.scl : link.sda;

  lpw_host u_lpw_host (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
                       .avs_readdata, .avs_waitrequest, .link(link));
  lpw_dev #(.N_CH(18)) u_lpw_dev (.clk_sys, .rst, .link(link), .channel_outputs,
                                  .channel_level);
  lpw_props u_lpw_props (.clk_sys, .rst, .scl(link.scl), .sda(link.sda),
                         .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));

  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_lvl(input int ch, input logic [4:0] e);
    cmp_count++;
    if (channel_level[ch] !== e) begin
      mismatches++;
      $display("Error level%0d expected %0h seen %0h", ch, e, channel_level[ch]);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    // no cycle count is assumed; only the watchdog ends a wait that never finishes
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  // order one link write and poll until the host is idle again
  task automatic send(input logic [7:0] i, input logic [7:0] d, input logic [7:0] e,
                      input logic two, input logic [1:0] ab);
    logic [31:0] q;
    av(1'b1, H_REG_CTRL, {1'b1, 4'h0, ab, two, e, d, i}, q);
    q = 32'h1;
    // poll until idle; a frame that never ends is caught by the watchdog
    while (q[STAT_BUSY_BIT] !== 1'b0) begin
      av(1'b0, H_REG_STATUS, 32'h0, q);
    end
    nk = q[STAT_NACK_BIT];
  endtask

  task automatic wr1(input logic [7:0] i, input logic [7:0] d);
    send(i, d, 8'h00, 1'b0, 2'h0);
  endtask

  // on-time of channels 0 and 1, and cycles where 1 leads 0
  task automatic meas(input int cy);
    c0 = 0;
    c1 = 0;
    cx = 0;
    repeat (cy) begin
      @(posedge clk_sys);
      c0 += int'(channel_outputs[0] === 1'b1);
      c1 += int'(channel_outputs[1] === 1'b1);
      cx += int'(channel_outputs[1] === 1'b1 && channel_outputs[0] !== 1'b1);
    end
  endtask

  task automatic t_addr();
    logic [1:0] ab [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    for (int m = 0; m < 4; m++) begin
      ad_mode <= m[1:0];
      @(posedge clk_sys);
      send(REG_SOFT_OFF, 8'h01, 8'h00, 1'b0, ab[m]);
      chk_bit("ack", 1'b0, nk);
      send(REG_SOFT_OFF, 8'h01, 8'h00, 1'b0, ~ab[m]);
      chk_bit("nack", 1'b1, nk);
    end
    ad_mode <= 2'h0;
    @(posedge clk_sys);
    $display("t_addr done");
  endtask

  task automatic t_shadow();
    wr1(REG_SOFT_OFF, 8'h01);
    send(REG_SCALE_FIRST, 8'h30, 8'h31, 1'b1, 2'h0);
    send(REG_DUTY_FIRST, 8'h80, 8'h40, 1'b1, 2'h0);
    wr1(REG_COMMIT, 8'h01);
    chk_lvl(0, 5'h00);
    wr1(REG_COMMIT, CMD_MAGIC);
    chk_lvl(0, 5'h18);
    chk_lvl(1, 5'h17);
    meas(256);
    chk_cnt("on0", 128, c0);
    chk_cnt("on1", 64, c1);
    chk_cnt("skew", 0, cx);
    $display("t_shadow done");
  endtask

  task automatic t_freq();
    wr1(REG_FREQ, 8'h01);
    meas(256 * DIV_SLOW);
    chk_cnt("slow", 128 * DIV_SLOW, c0);
    wr1(REG_FREQ, 8'h00);
    meas(256 * DIV_FAST);
    chk_cnt("fast", 128 * DIV_FAST, c0);
    $display("t_freq done");
  endtask

  // global off, global on, shutdown, back to normal: registers kept
  task automatic t_off();
    logic [7:0] rg [4] = '{REG_GLOBAL, REG_GLOBAL, REG_SOFT_OFF, REG_SOFT_OFF};
    // global bit one is off, shutdown bit zero is off
    logic [7:0] dv [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
    for (int k = 0; k < 4; k++) begin
      wr1(rg[k], dv[k]);
      meas(256);
      chk_cnt("gate", k[0] ? 128 : 0, c0);
    end
    $display("t_off done");
  endtask

  task automatic t_scale();
    for (int k = 0; k < 14; k++) begin
      wr1(REG_SCALE_FIRST, {2'h0, SC[k]});
      wr1(REG_COMMIT, CMD_MAGIC);
      chk_lvl(0, LV[k]);
    end
    meas(256);
    chk_cnt("off_code", 0, c0);
    $display("t_scale done");
  endtask

  task automatic t_dflt();
    wr1(REG_SCALE_FIRST, 8'h30);
    wr1(REG_COMMIT, CMD_MAGIC);
    send(8'h2E, 8'h11, CMD_MAGIC, 1'b1, 2'h0);
    chk_bit("unmapped", 1'b0, nk);
    chk_lvl(0, 5'h00);
    wr1(REG_SOFT_OFF, 8'h01);
    wr1(REG_COMMIT, CMD_MAGIC);
    chk_lvl(0, 5'h00);
    $display("t_dflt done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst           = 1'b1;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    ad_mode       = 2'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_bit("scl_idle", 1'b1, link.scl);
    chk_bit("sda_idle", 1'b1, link.sda);
    t_addr();
    t_shadow();
    t_freq();
    t_off();
    t_scale();
    t_dflt();
    print_verdict();
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    $display("Error watchdog expected done seen hang");
    print_verdict();
  end
endmodule
`default_nettype wire
